/* File: rtl/tcc_timer3.sv */
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer3 #(
    parameter int DIV_W = tcc_pkg::DIV_W
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic count_input_pin_i,
    input wire logic sub_clock_tick_i,
    output logic timer3_irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // registers and state
    tcc_pkg::tcc_ctrl_t ctrl_reg;
    tcc_pkg::tcc_sys_t sys_reg;
    logic [7:0] noise_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cmpa_reg;
    logic [7:0] capb_reg;
    logic lock_reg;
    logic irq_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick_en;
    logic [2:0] pin_sync_reg;
    logic sub_sync1_reg;
    logic sub_sync2_reg;
    logic sub_prev_reg;
    logic [7:0] flt_cnt_reg;
    logic flt_reg;
    logic flt_prev_reg;
    logic rise_ev;
    logic fall_ev;
    logic ev_edge;
    logic prim_edge;
    logic sec_edge;
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic wr_ctrl;
    logic rd_cmpa;
    logic [7:0] rd_mux;
    logic sub_tick;
    logic running;
    logic capture_mode;

    // pick a prescaler bit pulse: one cycle when bit idx rolls over
    function automatic logic tap_pulse(input logic [DIV_W-1:0] d, input int idx);
        logic [DIV_W-1:0] m;
        m = '0;
        for (int i = 0; i < DIV_W; i++)
        begin
            if (i <= idx)
                m[i] = 1'b1;
        end
        return (d & m) == m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
        end
        else if (hready_i)
        begin
            ap_valid_reg <= hsel_i && htrans_i[1];
            ap_write_reg <= hwrite_i;
            ap_addr_reg <= haddr_i[7:0];
        end
    end
    assign wr_ctrl = ap_valid_reg && ap_write_reg && ap_addr_reg == tcc_pkg::OFS_CTRL;
    assign rd_cmpa = ap_valid_reg && !ap_write_reg && ap_addr_reg == tcc_pkg::OFS_CMPA;

    // read mux, unmapped reads as zero
    always_comb
    begin
        rd_mux = 8'h00;
        case (ap_addr_reg)
            tcc_pkg::OFS_CTRL: rd_mux = ctrl_reg;
            tcc_pkg::OFS_CMPA: rd_mux = cmpa_reg;
            tcc_pkg::OFS_CAPB: rd_mux = capb_reg;
            tcc_pkg::OFS_CNT: rd_mux = cnt_reg;
            tcc_pkg::OFS_SYS: rd_mux = {5'h00, sys_reg};
            tcc_pkg::OFS_NOISE: rd_mux = noise_reg;
            default: rd_mux = 8'h00;
        endcase
    end
    assign hrdata_o = {24'h0000_00, rd_mux};

    // config registers
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sys_reg <= '0;
            noise_reg <= tcc_pkg::NOISE_RST;
        end
        else if (ap_valid_reg && ap_write_reg)
        begin
            if (ap_addr_reg == tcc_pkg::OFS_SYS)
                sys_reg <= hwdata_i[2:0];
            if (ap_addr_reg == tcc_pkg::OFS_NOISE)
                noise_reg <= hwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_sync_reg <= 3'b000;
            sub_sync1_reg <= 1'b0;
            sub_sync2_reg <= 1'b0;
            sub_prev_reg <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], count_input_pin_i};
            sub_sync1_reg <= sub_clock_tick_i;
            sub_sync2_reg <= sub_sync1_reg;
            sub_prev_reg <= sub_sync2_reg;
        end
    end
    assign sub_tick = sub_sync2_reg && !sub_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // prescaler: free running main clock divider
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_reg <= '0;
        end
        else
        begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // source clock select, halving doubles prescaler tap period, sub clock unaffected
    // slow mode gives only code 00 from sub clock
    always_comb
    begin
        tick_en = 1'b0;
        if (sys_reg.slow_mode || sys_reg.prescaler_source_select)
        begin
            if (ctrl_reg.source_clock_select == 2'b00)
                tick_en = sub_tick; // one count per sub clock tick
            else if (!sys_reg.slow_mode)
                tick_en = tap_pulse(div_reg,
                    (ctrl_reg.source_clock_select == 2'b01 ? tcc_pkg::TAP_01 : tcc_pkg::TAP_10)
                    + int'(sys_reg.prescaler_halving_select));
        end
        else
        begin
            case (ctrl_reg.source_clock_select)
                2'b00: tick_en = tap_pulse(div_reg,
                    tcc_pkg::TAP_00 + int'(sys_reg.prescaler_halving_select));
                2'b01: tick_en = tap_pulse(div_reg,
                    tcc_pkg::TAP_01 + int'(sys_reg.prescaler_halving_select));
                2'b10: tick_en = tap_pulse(div_reg,
                    tcc_pkg::TAP_10 + int'(sys_reg.prescaler_halving_select));
                default: tick_en = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // noise filter: level must stand noise_reg+1 cycles in capture mode
    assign capture_mode = ctrl_reg.mode == tcc_pkg::TCC_MODE_CAPTURE;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            flt_cnt_reg <= 8'h00;
            flt_reg <= 1'b0;
            flt_prev_reg <= 1'b0;
        end
        else
        begin
            flt_prev_reg <= flt_reg;
            // reject pulses shorter than noise time
            if (pin_sync_reg[2] == flt_reg)
                flt_cnt_reg <= 8'h00;
            else if (!capture_mode || flt_cnt_reg >= noise_reg)
            begin
                flt_reg <= pin_sync_reg[2];
                flt_cnt_reg <= 8'h00;
            end
            else
                flt_cnt_reg <= flt_cnt_reg + 8'h01;
        end
    end
    assign rise_ev = flt_reg && !flt_prev_reg;
    assign fall_ev = !flt_reg && flt_prev_reg;
    // event edge polarity, zero selects rising
    assign ev_edge = ctrl_reg.edge_polarity ? fall_ev : rise_ev;
    // capture edge select zero means rising primary
    assign prim_edge = ctrl_reg.cap_edge ? fall_ev : rise_ev;
    assign sec_edge = ctrl_reg.cap_edge ? rise_ev : fall_ev;
    assign running = ctrl_reg.start;

    ////////////////////////////////////////////////////////////////////////
    // control register, soft capture self clears
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ctrl_reg <= '0;
        else if (wr_ctrl)
            ctrl_reg <= hwdata_i[7:0];
        else
            ctrl_reg.soft_capture_request <= 1'b0;
    end

    // mode dependent counter, captures and interrupt
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= 8'h00;
            cmpa_reg <= 8'h00;
            capb_reg <= 8'h00;
            lock_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= 1'b0;
            // register A writable outside capture mode
            if (ap_valid_reg && ap_write_reg && ap_addr_reg == tcc_pkg::OFS_CMPA
                && !capture_mode)
                cmpa_reg <= hwdata_i[7:0];
            if (ctrl_reg.soft_capture_request && !capture_mode)
                capb_reg <= cnt_reg;
            if (rd_cmpa)
                lock_reg <= 1'b0;
            if (!running)
            begin
                cnt_reg <= 8'h00;
                lock_reg <= 1'b0;
            end
            else
            begin
                case (ctrl_reg.mode)
                    tcc_pkg::TCC_MODE_TIMER, tcc_pkg::TCC_MODE_EVENT:
                    begin
                        if (ctrl_reg.mode == tcc_pkg::TCC_MODE_TIMER ? tick_en : ev_edge)
                        begin
                            if (cnt_reg == cmpa_reg)
                            begin
                                cnt_reg <= 8'h00;
                                irq_reg <= 1'b1;
                            end
                            else
                                cnt_reg <= cnt_reg + 8'h01;
                        end
                    end
                    tcc_pkg::TCC_MODE_CAPTURE:
                    begin
                        if (prim_edge && !lock_reg)
                        begin
                            cmpa_reg <= cnt_reg;
                            cnt_reg <= 8'h00;
                            irq_reg <= 1'b1;
                            lock_reg <= 1'b1;
                        end
                        // overflow marks A with all ones
                        else if (tick_en && cnt_reg == tcc_pkg::CNT_ONES && !lock_reg)
                        begin
                            cmpa_reg <= tcc_pkg::CNT_ONES;
                            cnt_reg <= 8'h00;
                            irq_reg <= 1'b1;
                            lock_reg <= 1'b1;
                        end
                        else if (tick_en)
                            cnt_reg <= cnt_reg + 8'h01;
                        if (sec_edge && !lock_reg)
                            capb_reg <= cnt_reg;
                    end
                    default: cnt_reg <= cnt_reg;
                endcase
            end
        end
    end
    assign timer3_irq_o = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_timer_match_irq: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        running && ctrl_reg.mode == tcc_pkg::TCC_MODE_TIMER && tick_en && cnt_reg == cmpa_reg
        |=> timer3_irq_o && cnt_reg == 8'h00)
        else $error("timer match did not clear and interrupt");
    a_event_match_irq: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        running && ctrl_reg.mode == tcc_pkg::TCC_MODE_EVENT && ev_edge && cnt_reg == cmpa_reg
        |=> timer3_irq_o && cnt_reg == 8'h00)
        else $error("event match did not clear and interrupt");
    a_soft_capture_b: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ctrl_reg.soft_capture_request && !capture_mode && !wr_ctrl
        |=> capb_reg == $past(cnt_reg) && !ctrl_reg.soft_capture_request)
        else $error("soft capture failed");
    a_prim_capture: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        running && capture_mode && prim_edge && !lock_reg
        |=> cmpa_reg == $past(cnt_reg) && cnt_reg == 8'h00 && timer3_irq_o)
        else $error("primary edge capture wrong");
    a_sec_capture: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        running && capture_mode && sec_edge && !lock_reg && !tick_en
        |=> capb_reg == $past(cnt_reg) && cnt_reg == $past(cnt_reg))
        else $error("opposite edge capture wrong");
    a_overflow_mark: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        running && capture_mode && tick_en && cnt_reg == tcc_pkg::CNT_ONES && !lock_reg
        |=> cmpa_reg == tcc_pkg::CNT_ONES && cnt_reg == 8'h00 && timer3_irq_o)
        else $error("overflow not marked");
    a_lock_holds_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        capture_mode && running && lock_reg && !rd_cmpa |=> $stable(cmpa_reg))
        else $error("register A changed while locked");
    a_free_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        running && capture_mode && tick_en && !prim_edge && cnt_reg != tcc_pkg::CNT_ONES
        |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("capture counter not free running");
endmodule
`default_nettype wire

/* File: rtl/tcc_pkg.sv */
`default_nettype none
package tcc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMPA = 8'h04;
    localparam logic [7:0] OFS_CAPB = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0C;
    localparam logic [7:0] OFS_SYS = 8'h10;
    localparam logic [7:0] OFS_NOISE = 8'h14;
    // control field positions
    localparam int CK_LO = 0;
    localparam int MODE_LO = 2;
    localparam int START_BIT = 4;
    localparam int EDGE_BIT = 5;
    localparam int SOFT_CAPTURE_REQUEST_BIT = 6;
    localparam int CAPEDGE_BIT = 7;
    // system config field positions
    localparam int DV7_BIT = 0;
    localparam int DV1_BIT = 1;
    localparam int SLOW_BIT = 2;
    localparam logic [7:0] CNT_ONES = 8'hFF;
    localparam logic [7:0] NOISE_RST = 8'h07;
    // prescaler tap positions, as counter bit index (a tick every 2^(idx+1) system clocks)
    localparam int TAP_00 = 11;
    localparam int TAP_01 = 9;
    localparam int TAP_10 = 6;
    localparam int SUB_TAP_00 = 13;
    localparam int DIV_W = 16;
    typedef enum logic [1:0] {
        TCC_MODE_TIMER = 2'b00,
        TCC_MODE_EVENT = 2'b01,
        TCC_MODE_CAPTURE = 2'b10,
        TCC_MODE_OFF = 2'b11
    } tcc_mode_t;
    typedef struct packed {
        logic cap_edge;
        logic soft_capture_request;
        logic edge_polarity;
        logic start;
        tcc_mode_t mode;
        logic [1:0] source_clock_select;
    } tcc_ctrl_t;
    typedef struct packed {
        logic slow_mode;
        logic prescaler_halving_select;
        logic prescaler_source_select;
    } tcc_sys_t;
endpackage
`default_nettype wire

/* File: verif/tcc_pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse_src (
    input wire logic clk_sys_i,
    output logic pin_o
);
    // pin rests low until the bench asks for a level
    initial
    begin
        pin_o = 1'b0;
    end
    // drive one level and hold it for n clocks
    // two clock minimum
    task automatic drive(input logic lvl, input int n);
        int hold;
        hold = (n < 2) ? 2 : n;
        @(posedge clk_sys_i);
        pin_o <= lvl;
        repeat (hold - 1) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic sub_tick = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic hreadyout, hresp, irq, pin;
    logic [31:0] hrdata, q;
    int err_total = 0, checks_done = 0, irq_cnt = 0, cyc = 0, irq_cyc = 0, irq_gap = 0;
    int sub_div = 0;
    tcc_timer3 dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .count_input_pin_i(pin),
        .sub_clock_tick_i(sub_tick), .timer3_irq_o(irq));
    tcc_pulse_src src_u (.clk_sys_i(clk_sys_i), .pin_o(pin));
    // system clock
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // irq pulse counter and spacing between pulses
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (irq === 1'b1)
        begin
            irq_cnt <= irq_cnt + 1;
            irq_gap <= cyc - irq_cyc;
            irq_cyc <= cyc;
        end
    end
    // sub clock square wave, 40 system clocks a period
    always @(posedge clk_sys_i)
    begin
        if (sub_div == 19)
        begin
            sub_div <= 0;
            sub_tick <= ~sub_tick;
        end
        else
            sub_div <= sub_div + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // count value measured against a free clock: one tick either way
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp && got !== exp + 1 && got !== exp - 1)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_up();
        err_total++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    endtask
    // one single ahb-lite word transfer, read data left in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= 32'(a);
        hwrite_i <= w;
        hsize_i <= 3'h2;
        // address phase stands until hready is seen high at an edge
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        // data phase stands until hready is seen high again
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        q = hrdata;
        if (n >= 50)
            give_up();
    endtask
    // wait until irq_cnt passes base
    task automatic wait_irq(input int base, input int max);
        int n;
        n = 0;
        while (irq_cnt <= base && n < max)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= max)
            give_up();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] ofs[7];
        ofs = '{tcc_pkg::OFS_CTRL, tcc_pkg::OFS_CMPA, tcc_pkg::OFS_CAPB, tcc_pkg::OFS_CNT,
            tcc_pkg::OFS_SYS, tcc_pkg::OFS_NOISE, 8'h18};
        bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_0055);
        bus(1'b1, tcc_pkg::OFS_CAPB, 32'h0000_0066);
        bus(1'b1, 8'h18, 32'h0000_0077);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, ofs[i], 32'h0000_0000);
            chk_eq(q, (i == 5) ? 32'(tcc_pkg::NOISE_RST) : 32'h0000_0000);
        end
        chk_eq(32'(hresp), 32'h0000_0000);
    endtask
    task automatic t_timer();
        logic [7:0] ctl[4] = '{8'h10, 8'h11, 8'h12, 8'h12};
        logic [7:0] sys[4] = '{8'h00, 8'h00, 8'h00, 8'h02};
        int per[4] = '{8192, 2048, 256, 512};
        bus(1'b1, tcc_pkg::OFS_CMPA, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, tcc_pkg::OFS_SYS, 32'(sys[i]));
            bus(1'b1, tcc_pkg::OFS_CTRL, 32'(ctl[i]));
            wait_irq(irq_cnt + 1, 20000);
            chk_eq(32'(irq_gap), 32'(per[i]));
            bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
        end
        bus(1'b1, tcc_pkg::OFS_SYS, 32'h0000_0000);
    endtask
    // pulses of 10 clocks a level keep the event rate below clock/16
    task automatic t_event();
        int base;
        base = irq_cnt;
        bus(1'b1, tcc_pkg::OFS_CMPA, 32'h0000_0005);
        bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0014);
        for (int i = 0; i < 6; i++)
        begin
            src_u.drive(1'b1, 10);
            if (i == 3)
            begin
                bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0074);
                bus(1'b0, tcc_pkg::OFS_CAPB, 32'h0000_0000);
                chk_eq(q, 32'h0000_0003);
            end
            src_u.drive(1'b0, 10);
            if (i == 2)
            begin
                bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0054);
                bus(1'b0, tcc_pkg::OFS_CAPB, 32'h0000_0000);
                chk_eq(q, 32'h0000_0003);
                bus(1'b0, tcc_pkg::OFS_CTRL, 32'h0000_0000);
                chk_eq(q, 32'h0000_0014);
                bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0034);
            end
            if (i == 4)
                chk_eq(32'(irq_cnt), 32'(base));
        end
        chk_eq(32'(irq_cnt), 32'(base + 1));
        bus(1'b0, tcc_pkg::OFS_CNT, 32'h0000_0000);
        chk_eq(q, 32'h0000_0000);
        bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
    endtask
    task automatic t_cap();
        int base;
        base = irq_cnt;
        bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_001A);
        src_u.drive(1'b1, 1280);
        chk_eq(32'(irq_cnt), 32'(base + 1));
        bus(1'b0, tcc_pkg::OFS_CMPA, 32'h0000_0000);
        src_u.drive(1'b0, 2560);
        src_u.drive(1'b1, 200);
        chk_eq(32'(irq_cnt), 32'(base + 2));
        bus(1'b0, tcc_pkg::OFS_CAPB, 32'h0000_0000);
        chk_near(q, 32'h0000_000A);
        src_u.drive(1'b0, 2560);
        src_u.drive(1'b1, 200);
        chk_eq(32'(irq_cnt), 32'(base + 2));
        bus(1'b0, tcc_pkg::OFS_CMPA, 32'h0000_0000);
        chk_near(q, 32'h0000_001E);
        src_u.drive(1'b0, 4);
        src_u.drive(1'b1, 40);
        chk_eq(32'(irq_cnt), 32'(base + 2));
        bus(1'b1, tcc_pkg::OFS_NOISE, 32'h0000_0002);
        src_u.drive(1'b0, 4);
        src_u.drive(1'b1, 40);
        chk_eq(32'(irq_cnt), 32'(base + 3));
        bus(1'b0, tcc_pkg::OFS_CMPA, 32'h0000_0000);
        wait_irq(base + 3, 34000);
        bus(1'b0, tcc_pkg::OFS_CMPA, 32'h0000_0000);
        chk_eq(q, 32'h0000_00FF);
        bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
    endtask
    task automatic t_slow();
        int base;
        // compare value of one: two ticks a period
        bus(1'b1, tcc_pkg::OFS_CMPA, 32'h0000_0001);
        bus(1'b1, tcc_pkg::OFS_SYS, 32'h0000_0004);
        base = irq_cnt;
        bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0011);
        repeat (3000) @(posedge clk_sys_i);
        chk_eq(32'(irq_cnt), 32'(base));
        bus(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0010);
        wait_irq(base + 1, 400);
        chk_eq(32'(irq_gap), 32'h0000_0050);
        // sub clock source in normal mode, same rate
        bus(1'b1, tcc_pkg::OFS_SYS, 32'h0000_0001);
        wait_irq(irq_cnt + 1, 400);
        chk_eq(32'(irq_gap), 32'h0000_0050);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // reset, then each scenario in turn
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_regs();
        t_timer();
        t_event();
        t_cap();
        t_slow();
        tally_and_finish();
    end
endmodule
`default_nettype wire
